// ==== src/irl_consts.svh ====
// Constants of the interrupt request logic
`ifndef IRL_CONSTS_SVH
`define IRL_CONSTS_SVH
`define IRL_INFO_ADDR        20'h0_0000
`define IRL_SP_RESET         16'h0000
`define IRL_NMI_LEVEL_BIT    5
`define IRL_DEBOUNCE_OFF     8'hFF
`define IRL_DEBOUNCE_RESET   8'h00
`define IRL_NMI_EXTRA_NS     300
`define IRL_CLK_PERIOD_NS    100
// Least hold in cycles: 2 + ceil(300/100)
`define IRL_NMI_HOLD_CYC     (2 + ((`IRL_NMI_EXTRA_NS + `IRL_CLK_PERIOD_NS - 1) / `IRL_CLK_PERIOD_NS))
`endif

// ==== src/irl_pkg.sv ====
// Types of the interrupt request logic
package irl_pkg;
  typedef logic [2:0] irl_level_t;
  typedef logic [15:0] irl_sp_t;
  typedef logic [19:0] irl_addr_t;
  typedef enum logic [1:0] {
    IRL_ST_RUN,
    IRL_ST_ACK,
    IRL_ST_NMI_HALT
  } irl_state_e;
endpackage

// ==== src/irl_source_flag.sv ====
// One request source: edge detect, polarity, spurious set on change, flag
`timescale 1ns/1ns
`default_nettype none
module irl_source_flag (
  input  wire logic clock_in,         // CPU clock
  input  wire logic rst_in,           // Async reset, high
  input  wire logic req_in,           // Request line level
  input  wire logic edge_polarity_in, // 1 rising, 0 falling
  input  wire logic select_in,        // Source select
  input  wire logic clear_in,         // Clear pulse
  input  wire logic write_in,         // Plain store of flag
  input  wire logic write_val_in,     // Stored value
  output logic      flag_out          // Request pending flag
);
  logic req_reg;
  logic req_next;
  logic cfg_reg;
  logic cfg_next;
  logic sel_reg;
  logic sel_next;
  logic flag_reg;
  logic flag_next;
  logic eff;
  logic prev_eff;

  always_comb begin
    req_next  = req_in;
    cfg_next  = edge_polarity_in;
    sel_next  = select_in;
    eff       = (req_in ^ ~edge_polarity_in) & select_in;
    prev_eff  = (req_reg ^ ~cfg_reg) & sel_reg;
    flag_next = flag_reg;
    if (clear_in) begin
      flag_next = 1'b0;
    end else if (write_in) begin
      flag_next = write_val_in;
    end
    // Set wins over clear; config change may produce an edge too
    if (eff & ~prev_eff) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      req_reg  <= 1'b0;
      cfg_reg  <= 1'b1;
      sel_reg  <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      req_reg  <= req_next;
      cfg_reg  <= cfg_next;
      sel_reg  <= sel_next;
      flag_reg <= flag_next;
    end
  end

  assign flag_out = flag_reg;
endmodule
`default_nettype wire

// ==== src/irl_top.sv ====
// Interrupt request, acknowledge and NMI control logic
`timescale 1ns/1ns
`default_nettype none
`include "irl_consts.svh"
module irl_top #(
  parameter int NUM_SRC = 8
) (
  input  wire logic                   clock_in,           // CPU clock 10 MHz
  input  wire logic                   rst_in,             // Async reset, high
  input  wire logic [NUM_SRC-1:0]     req_in,             // Source request lines
  input  wire logic [NUM_SRC-1:0]     edge_polarity_in,   // Per-source polarity
  input  wire logic [NUM_SRC-1:0]     source_select_in,   // Per-source select
  input  wire logic [NUM_SRC*3-1:0]   level_in,           // Per-source priority
  input  wire logic [NUM_SRC-1:0]     flag_write_in,      // Plain store of flag
  input  wire logic [NUM_SRC-1:0]     flag_write_val_in,  // Stored flag value
  input  wire logic                   global_enable_in,   // Global enable flag
  input  wire irl_pkg::irl_level_t    cpu_level_in,       // Processor level
  input  wire logic                   ack_in,             // CPU acknowledge cycle
  input  wire logic                   rd_in,              // Program read strobe
  input  wire irl_pkg::irl_addr_t     rd_addr_in,         // Program read address
  input  wire logic                   usp_we_in,          // User SP write
  input  wire logic                   isp_we_in,          // Interrupt SP write
  input  wire irl_pkg::irl_sp_t       sp_wdata_in,        // SP write data
  input  wire logic                   nmi_en_we_in,       // NMI enable write
  input  wire logic                   nmi_en_wdata_in,    // NMI enable value
  input  wire logic                   nmi_n_in,           // NMI pin, low active
  input  wire logic                   stop_we_in,         // Stop bit write
  input  wire logic                   stop_wdata_in,      // Stop bit value
  input  wire logic                   nmi_dbnc_we_in,     // NMI debounce write
  input  wire logic                   ext_irq_five_pin_dbnc_we_in,    // Input five debounce write
  input  wire logic [7:0]             dbnc_wdata_in,      // Debounce write data
  output logic                        irq_out,            // Maskable request to CPU
  output logic [7:0]                  irq_num_out,        // Info: number
  output irl_pkg::irl_level_t         irq_level_out,      // Info: level
  output logic                        nmi_irq_out,        // NMI request pulse
  output logic                        cpu_halt_out,       // CPU halted by NMI
  output logic [NUM_SRC-1:0]          flag_out,           // Request pending flags
  output irl_pkg::irl_sp_t            user_stack_pointer_out, // User SP
  output irl_pkg::irl_sp_t            irq_stack_pointer_out,  // Interrupt SP
  output logic                        nmi_enable_bit_out, // NMI enable state
  output logic [7:0]                  port_eight_data_out,// Port eight readback
  output logic                        stop_entry_bit_out, // Stop entry bit
  output logic [7:0]                  nmi_debounce_out,   // NMI debounce reg
  output logic [7:0]                  ext_irq_five_debounce_out // Input five debounce
);
  import irl_pkg::*;

  // Index must fit the eight-bit interrupt number
  if (NUM_SRC < 1 || NUM_SRC > 256) begin : g_bad_num_src
    $error("NUM_SRC out of range");
  end

  localparam int IDX_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

  // ----------------------------------------
  // Request flags
  // ----------------------------------------
  logic [NUM_SRC-1:0] clr_vec;
  logic [NUM_SRC-1:0] flags;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      irl_source_flag u_flag (
        .clock_in         (clock_in),
        .rst_in           (rst_in),
        .req_in           (req_in[g]),
        .edge_polarity_in (edge_polarity_in[g]),
        .select_in        (source_select_in[g]),
        .clear_in         (clr_vec[g]),
        .write_in         (flag_write_in[g]),
        .write_val_in     (flag_write_val_in[g]),
        .flag_out         (flags[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Priority resolution
  // ----------------------------------------
  logic             best_valid;
  logic [IDX_W-1:0] best_idx;
  irl_level_t       best_lvl;

  always_comb begin
    best_valid = 1'b0;
    best_idx   = '0;
    best_lvl   = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      // Level zero means source disabled; ties go to lower index
      if (flags[i] && level_in[i*3 +: 3] != 3'h0 && level_in[i*3 +: 3] > best_lvl) begin
        best_valid = 1'b1;
        best_idx   = IDX_W'(i);
        best_lvl   = level_in[i*3 +: 3];
      end
    end
  end

  logic accept_ok;
  assign accept_ok = best_valid && global_enable_in && (best_lvl > cpu_level_in);

  logic info_read;
  assign info_read = rd_in && (rd_addr_in == `IRL_INFO_ADDR);

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  irl_state_e state_reg;
  irl_state_e state_next;
  logic [7:0] num_reg;
  logic [7:0] num_next;
  irl_level_t lvl_reg;
  irl_level_t lvl_next;
  irl_sp_t    usp_reg;
  irl_sp_t    usp_next;
  irl_sp_t    isp_reg;
  irl_sp_t    isp_next;
  logic       nmi_en_reg;
  logic       nmi_en_next;
  logic       nmi_irq_reg;
  logic       nmi_irq_next;
  logic       nmi_pin_reg;
  logic       nmi_pin_next;
  logic       stop_reg;
  logic       stop_next;
  logic [7:0] ndb_reg;
  logic [7:0] ndb_next;
  logic [7:0] idb_reg;
  logic [7:0] idb_next;
  logic       nmi_fall;

  // Pin seen high last cycle and low now, with the function enabled
  assign nmi_fall = nmi_en_reg && nmi_pin_reg && !nmi_n_in;

  always_comb begin
    state_next   = state_reg;
    num_next     = num_reg;
    lvl_next     = lvl_reg;
    usp_next     = usp_we_in ? sp_wdata_in : usp_reg;
    isp_next     = isp_we_in ? sp_wdata_in : isp_reg;
    nmi_pin_next = nmi_n_in;
    nmi_irq_next = 1'b0;
    clr_vec      = '0;
    ndb_next     = nmi_dbnc_we_in ? dbnc_wdata_in : ndb_reg;
    idb_next     = ext_irq_five_pin_dbnc_we_in ? dbnc_wdata_in : idb_reg;
    // Enable only goes one way until reset
    nmi_en_next  = nmi_en_reg | (nmi_en_we_in & nmi_en_wdata_in);
    // Enabling while pin already low fires at once
    if (nmi_en_we_in && nmi_en_wdata_in && !nmi_en_reg && !nmi_n_in) begin
      nmi_irq_next = 1'b1;
    end else if (nmi_fall) begin
      nmi_irq_next = 1'b1;
    end
    stop_next = stop_we_in ? stop_wdata_in : stop_reg;
    if (nmi_en_reg && !nmi_n_in) begin
      stop_next = 1'b0;
    end
    // Program read of info address clears the best pending flag, as an acknowledge does
    if (info_read && best_valid) begin
      clr_vec[best_idx] = 1'b1;
    end
    case (state_reg)
      IRL_ST_RUN: begin
        if (ack_in && accept_ok) begin
          num_next          = 8'(best_idx);
          lvl_next          = best_lvl;
          clr_vec[best_idx] = 1'b1;
          state_next        = IRL_ST_ACK;
        end
      end
      IRL_ST_ACK: begin
        if (!ack_in) begin
          state_next = IRL_ST_RUN;
        end
      end
      IRL_ST_NMI_HALT: begin
        // Resume on a later maskable request; the halting NMI itself does not count
        if (accept_ok) begin
          state_next = IRL_ST_RUN;
        end
      end
      default: begin
        state_next = IRL_ST_RUN;
      end
    endcase
    // A falling NMI edge halts from any state, after any acceptance above
    if (nmi_fall) begin
      state_next = IRL_ST_NMI_HALT;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg   <= IRL_ST_RUN;
      num_reg     <= 8'h00;
      lvl_reg     <= 3'h0;
      usp_reg     <= `IRL_SP_RESET;
      isp_reg     <= `IRL_SP_RESET;
      nmi_en_reg  <= 1'b0;
      nmi_irq_reg <= 1'b0;
      nmi_pin_reg <= 1'b1;
      stop_reg    <= 1'b0;
      ndb_reg     <= `IRL_DEBOUNCE_RESET;
      idb_reg     <= `IRL_DEBOUNCE_RESET;
    end else begin
      state_reg   <= state_next;
      num_reg     <= num_next;
      lvl_reg     <= lvl_next;
      usp_reg     <= usp_next;
      isp_reg     <= isp_next;
      nmi_en_reg  <= nmi_en_next;
      nmi_irq_reg <= nmi_irq_next;
      nmi_pin_reg <= nmi_pin_next;
      stop_reg    <= stop_next;
      ndb_reg     <= ndb_next;
      idb_reg     <= idb_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign irq_out                   = accept_ok && (state_reg == IRL_ST_RUN || state_reg == IRL_ST_NMI_HALT);
  assign irq_num_out               = num_reg;
  assign irq_level_out             = lvl_reg;
  assign nmi_irq_out               = nmi_irq_reg;
  assign cpu_halt_out              = (state_reg == IRL_ST_NMI_HALT);
  assign flag_out                  = flags;
  assign user_stack_pointer_out    = usp_reg;
  assign irq_stack_pointer_out     = isp_reg;
  assign nmi_enable_bit_out        = nmi_en_reg;
  assign port_eight_data_out       = {2'b00, nmi_pin_reg, 5'b0_0000};
  assign stop_entry_bit_out        = stop_reg;
  assign nmi_debounce_out          = ndb_reg;
  assign ext_irq_five_debounce_out = idb_reg;
endmodule
`default_nettype wire

// ==== test/irl_nmi_driver.sv ====
// Far-side driver of the NMI pin, holding each level a least time
`timescale 1ns/1ns
`default_nettype none
module irl_nmi_driver #(
  parameter int HOLD = 5
) (
  input  wire logic clock_in,  // Clock
  input  wire logic rst_in,    // Reset
  input  wire logic level_in,  // Wanted pin level
  output logic      nmi_n_out  // Pin, low active
);
  logic [3:0] cnt_reg, cnt_next;
  logic       pin_reg, pin_next;
  // A new level waits until the old one has lasted HOLD cycles
  always_comb begin
    pin_next = pin_reg;
    cnt_next = (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
    if (cnt_reg == 4'h0 && level_in != pin_reg) begin
      pin_next = level_in;
      cnt_next = 4'(HOLD - 1);
    end
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= 4'h0;
      pin_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      pin_reg <= pin_next;
    end
  end
  assign nmi_n_out = pin_reg;
endmodule
`default_nettype wire

// ==== test/irl_top_bench.sv ====
// Self-checking bench of the interrupt request logic
`timescale 1ns/1ns
`default_nettype none
`include "irl_consts.svh"
module irl_top_bench;
  import irl_pkg::*;
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  req_in, edge_polarity_in, source_select_in, flag_write_in, flag_write_val_in;
  logic [23:0] level_in;
  logic        global_enable_in, ack_in, rd_in, usp_we_in, isp_we_in, nmi_en_we_in, nmi_en_wdata_in;
  logic        nmi_n_in, stop_we_in, stop_wdata_in, nmi_dbnc_we_in, ext_irq_five_pin_dbnc_we_in, irq_out, nmi_irq_out;
  logic        cpu_halt_out, nmi_enable_bit_out, stop_entry_bit_out, pin_level;
  irl_level_t  cpu_level_in, irq_level_out;
  irl_addr_t   rd_addr_in;
  irl_sp_t     sp_wdata_in, user_stack_pointer_out, irq_stack_pointer_out;
  logic [7:0]  dbnc_wdata_in, irq_num_out, flag_out, port_eight_data_out;
  logic [7:0]  nmi_debounce_out, ext_irq_five_debounce_out;
  int          fail_count = 0;
  int          compares = 0;
  always #50 clock_in = ~clock_in;
  irl_top i_irl_top (.*);
  irl_nmi_driver #(.HOLD(`IRL_NMI_HOLD_CYC)) i_irl_nmi_driver (.clock_in, .rst_in, .level_in(pin_level),
    .nmi_n_out(nmi_n_in));
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic ack(input logic [7:0] num, input irl_level_t lvl, input logic [7:0] left);
    cyc(1);
    ack_in <= 1'b1;
    cyc(1);
    ack_in <= 1'b0;
    @(negedge clock_in);
    chk("irq_num", num, irq_num_out);
    chk("irq_level", lvl, irq_level_out);
    chk("flags", left, flag_out);
  endtask
  task automatic clr(input logic [7:0] mask);
    cyc(1);
    flag_write_in <= mask;
    cyc(1);
    flag_write_in <= 8'h00;
    @(negedge clock_in);
    chk("flags", 8'h00, flag_out);
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    @(negedge clock_in);
    chk("nmi_en", 1'h0, nmi_enable_bit_out);
    chk("port8", 8'h20, port_eight_data_out);
    chk("debounce", 8'h00, nmi_debounce_out);
    chk("usp", 16'h0000, user_stack_pointer_out);
    chk("isp", 16'h0000, irq_stack_pointer_out);
    cyc(1);
    {usp_we_in, isp_we_in, sp_wdata_in} <= {2'h3, 16'h1234};
    cyc(1);
    {usp_we_in, isp_we_in} <= 2'h0;
    @(negedge clock_in);
    chk("usp", 16'h1234, user_stack_pointer_out);
    chk("isp", 16'h1234, irq_stack_pointer_out);
    $display("reset test done");
  endtask
  task automatic t_accept;
    cyc(1);
    req_in <= 8'h0A;
    cyc(3);
    @(negedge clock_in);
    chk("flags", 8'h0A, flag_out);
    chk("irq no global", 1'h0, irq_out);
    cyc(1);
    {global_enable_in, cpu_level_in} <= {1'b1, 3'h5};
    cyc(1);
    @(negedge clock_in);
    chk("irq low level", 1'h0, irq_out);
    cpu_level_in <= 3'h1;
    ack(8'h03, 3'h5, 8'h02);
    ack(8'h01, 3'h2, 8'h00);
    $display("accept test done");
  endtask
  task automatic t_info;
    cyc(1);
    req_in <= 8'h4E;
    cyc(3);
    {rd_in, rd_addr_in} <= {1'b1, 20'h0_0001};
    cyc(1);
    rd_addr_in <= 20'h0_0000;
    cyc(1);
    rd_in <= 1'b0;
    @(negedge clock_in);
    chk("flags", 8'h04, flag_out);
    clr(8'h04);
    cyc(1);
    global_enable_in <= 1'b0;
    edge_polarity_in <= 8'hEF;
    cyc(3);
    @(negedge clock_in);
    chk("flags", 8'h10, flag_out);
    clr(8'h10);
    cyc(1);
    global_enable_in <= 1'b1;
    $display("info test done");
  endtask
  task automatic t_nmi;
    cyc(1);
    pin_level <= 1'b0;
    cyc(8);
    @(negedge clock_in);
    chk("halt", 1'h0, cpu_halt_out);
    chk("port8", 8'h00, port_eight_data_out);
    {nmi_en_we_in, nmi_en_wdata_in} <= 2'h3;
    cyc(1);
    nmi_en_wdata_in <= 1'b0;
    @(negedge clock_in);
    chk("nmi pulse", 1'h1, nmi_irq_out);
    {stop_we_in, stop_wdata_in} <= 2'h3;
    cyc(1);
    {nmi_en_we_in, stop_we_in} <= 2'h0;
    @(negedge clock_in);
    chk("nmi_en", 1'h1, nmi_enable_bit_out);
    chk("stop", 1'h0, stop_entry_bit_out);
    pin_level <= 1'b1;
    cyc(8);
    stop_we_in <= 1'b1;
    cyc(1);
    {stop_we_in, pin_level} <= 2'h0;
    @(negedge clock_in);
    chk("stop", 1'h1, stop_entry_bit_out);
    cyc(2);
    @(negedge clock_in);
    chk("halt", 1'h1, cpu_halt_out);
    chk("stop", 1'h0, stop_entry_bit_out);
    {flag_write_in, flag_write_val_in} <= {8'h08, 8'h08};
    cyc(1);
    flag_write_in <= 8'h00;
    @(negedge clock_in);
    chk("halt", 1'h1, cpu_halt_out);
    cyc(1);
    @(negedge clock_in);
    chk("halt", 1'h0, cpu_halt_out);
    ack(8'h03, 3'h5, 8'h00);
    {nmi_dbnc_we_in, ext_irq_five_pin_dbnc_we_in, dbnc_wdata_in} <= {2'h3, 8'hFF};
    cyc(1);
    {nmi_dbnc_we_in, ext_irq_five_pin_dbnc_we_in} <= 2'h0;
    @(negedge clock_in);
    chk("debounce", {8'hFF, 8'hFF}, {nmi_debounce_out, ext_irq_five_debounce_out});
    rst_in <= 1'b1;
    cyc(2);
    rst_in <= 1'b0;
    @(negedge clock_in);
    chk("nmi_en", 1'h0, nmi_enable_bit_out);
    chk("usp", 16'h0000, user_stack_pointer_out);
    $display("nmi test done");
  endtask
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
  initial begin
    {req_in, flag_write_in, flag_write_val_in, global_enable_in, ack_in, rd_in, rd_addr_in} = '0;
    {usp_we_in, isp_we_in, sp_wdata_in, nmi_en_we_in, nmi_en_wdata_in, stop_we_in, stop_wdata_in} = '0;
    {nmi_dbnc_we_in, ext_irq_five_pin_dbnc_we_in, dbnc_wdata_in} = '0;
    {edge_polarity_in, source_select_in, level_in} = {8'hFF, 8'hFF, 24'h18_0B10};
    {cpu_level_in, pin_level} = {3'h1, 1'b1};
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    t_reset();
    t_accept();
    t_info();
    t_nmi();
    summarize();
  end
endmodule
`default_nettype wire

// ==== test/irl_top_monitor.sv ====
// Port checker of the interrupt request logic
`timescale 1ns/1ns
`default_nettype none
module irl_top_monitor #(
  parameter int NUM_SRC = 8
) (
  input wire logic                clock_in,            // Clock
  input wire logic                rst_in,              // Reset
  input wire logic                global_enable_in,    // Global enable
  input wire irl_pkg::irl_level_t cpu_level_in,        // CPU level
  input wire logic                ack_in,              // Acknowledge
  input wire logic                nmi_en_we_in,        // NMI enable write
  input wire logic                nmi_en_wdata_in,     // NMI enable value
  input wire logic                nmi_n_in,            // NMI pin
  input wire logic                stop_we_in,          // Stop write
  input wire logic                stop_wdata_in,       // Stop value
  input wire logic                irq_out,             // Request
  input wire logic [7:0]          irq_num_out,         // Number
  input wire irl_pkg::irl_level_t irq_level_out,       // Level
  input wire logic                nmi_irq_out,         // NMI pulse
  input wire logic                cpu_halt_out,        // Halt
  input wire logic [NUM_SRC-1:0]  flag_out,            // Flags
  input wire logic                nmi_enable_bit_out,  // NMI enable
  input wire logic [7:0]          port_eight_data_out, // Readback
  input wire logic                stop_entry_bit_out   // Stop bit
);
  import irl_pkg::*;
  wire set_nmi = nmi_en_we_in && nmi_en_wdata_in;
  wire stop_one = stop_we_in && stop_wdata_in;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  nmi_sticky_a: assert property (nmi_enable_bit_out |=> nmi_enable_bit_out)
    else $error("nmi enable dropped");
  nmi_set_a: assert property (set_nmi |=> nmi_enable_bit_out)
    else $error("nmi enable not set");
  nmi_off_a: assert property (!nmi_enable_bit_out && !set_nmi |=> !nmi_enable_bit_out)
    else $error("nmi enable set unasked");
  nmi_low_en_a: assert property (set_nmi && !nmi_enable_bit_out && !nmi_n_in |=> nmi_irq_out)
    else $error("no nmi on enable with pin low");
  nmi_halt_a: assert property (nmi_enable_bit_out && $fell(nmi_n_in) |=> nmi_irq_out && cpu_halt_out)
    else $error("no halt on nmi fall");
  pin_read_a: assert property (1'b1 |=> port_eight_data_out == {2'h0, $past(nmi_n_in), 5'h00})
    else $error("pin readback wrong");
  stop_hold_a: assert property (stop_one && nmi_enable_bit_out && !nmi_n_in |=> !stop_entry_bit_out)
    else $error("stop bit set with pin low");
  ack_take_a: assert property (ack_in && irq_out |=> !flag_out[irq_num_out[2:0]]
    && irq_level_out > $past(cpu_level_in)) else $error("acceptance wrong");
  irq_gate_a: assert property (irq_out |-> global_enable_in)
    else $error("request without global enable");
endmodule
bind irl_top irl_top_monitor #(.NUM_SRC(NUM_SRC)) i_irl_top_monitor (.*);
`default_nettype wire
